// file: rtl/motor_start_params.svh
// Constants of the motor start-up supervision stage: limits, defaults and timing.
// Assumes currents and current settings in steps of 0.01 x motor_nominal_current,
// and time settings in steps of 0.1 s.
`ifndef MOTOR_START_PARAMS_SVH
`define MOTOR_START_PARAMS_SVH

// ==========================================================================
// Clock and time base
// ==========================================================================
`define MS_CLK_HZ           200000000
`define MS_TICK_MS          1
`define MS_TICK_CYCLES_DEF  ((`MS_CLK_HZ / 1000) * `MS_TICK_MS)
`define MS_STOP_MIN_MS      10'h1F4
`define MS_RISE_MAX_MS      8'hC8
`define MS_OPER_STEP_MS     7'h64

// ==========================================================================
// Fixed current limits, 0.01 x nominal per step
// ==========================================================================
`define MS_STOPPED_LIM      16'h000A
`define MS_RUN_LOW_LIM      16'h0014
`define MS_RUN_HIGH_LIM     16'h0078

// ==========================================================================
// Setting ranges and reset values
// ==========================================================================
`define MS_THR_MIN          16'h0082
`define MS_THR_MAX          16'h03E8
`define MS_THR_DEF          16'h0258
`define MS_RATED_MIN        16'h0096
`define MS_RATED_MAX        16'h03E8
`define MS_RATED_DEF        16'h0258
`define MS_DT_MIN           16'h000A
`define MS_DT_MAX           16'h0BB8
`define MS_DT_DEF           16'h000A
`define MS_K_MIN            16'h000A
`define MS_K_MAX            16'h07D0
`define MS_K_DEF            16'h000A

`endif

// file: rtl/motor_start_pkg.sv
// Types shared by the motor start-up supervision stage.
// Assumes nothing of its surroundings.
`default_nettype none

package motor_start_pkg;

  // ========================================================================
  // Motor state and delay type
  // ========================================================================
  typedef enum logic [1:0] {
    ST_STOPPED,
    ST_RISE,
    ST_STARTING,
    ST_RUNNING
  } motor_state_t;

  typedef enum logic {
    FIXED_DELAY_TYPE,
    INVERSE_DELAY_TYPE
  } delay_kind_t;

endpackage

`default_nettype wire

// file: rtl/div_req_if.sv
// Request and answer bundle between the supervision core and its divider.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Divider request interface
// ==========================================================================
interface div_req_if;
  logic        start;
  logic [39:0] numer;
  logic [39:0] denom;
  logic        busy;
  logic        done;
  logic [39:0] quot;

  modport calc (input start, input numer, input denom, output busy, output done, output quot);
  modport user (output start, output numer, output denom, input busy, input done, input quot);
endinterface

`default_nettype wire

// file: rtl/delay_divider.sv
// Sequential restoring divider used for the current-dependent operate time.
// Assumes an active-low reset released in step with the clock, one start pulse while idle.
`timescale 1ns/1ps
`default_nettype none

module delay_divider (
  input  wire logic  clk,
  input  wire logic  rst_n,
  div_req_if.calc    div
);

  logic [40:0] rem;
  logic [39:0] quo;
  logic [39:0] den;
  logic [5:0]  step;
  logic        busy;
  logic        done;
  logic [40:0] next_rem;
  logic [39:0] next_quo;
  logic [39:0] next_den;
  logic [5:0]  next_step;
  logic        next_busy;
  logic        next_done;
  logic [40:0] shifted;

  // ========================================================================
  // One quotient bit per cycle; forty cycles per division.
  // ========================================================================
  always_comb begin
    next_rem  = rem;
    next_quo  = quo;
    next_den  = den;
    next_step = step;
    next_busy = busy;
    next_done = 1'b0;
    shifted   = {rem[39:0], quo[39]};
    if (!busy) begin
      if (div.start) begin
        next_rem  = 41'h0;
        next_quo  = div.numer;
        next_den  = div.denom;
        next_step = 6'h00;
        next_busy = 1'b1;
      end
    end else if (den == 40'h0) begin
      // A zero divisor saturates rather than hanging the caller.
      next_quo  = 40'hFF_FFFF_FFFF;
      next_busy = 1'b0;
      next_done = 1'b1;
    end else begin
      if (shifted >= {1'b0, den}) begin
        next_rem = shifted - {1'b0, den};
        next_quo = {quo[38:0], 1'b1};
      end else begin
        next_rem = shifted;
        next_quo = {quo[38:0], 1'b0};
      end
      next_step = step + 6'h01;
      if (step == 6'h27) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem  <= 41'h0;
      quo  <= 40'h0;
      den  <= 40'h0;
      step <= 6'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      rem  <= next_rem;
      quo  <= next_quo;
      den  <= next_den;
      step <= next_step;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign div.busy = busy;
  assign div.done = done;
  assign div.quot = quo;

endmodule

`default_nettype wire

// file: rtl/motor_start_supervision.sv
// Motor start-up supervision stage: motor state tracking, start and trip timing.
// Assumes phase currents are fundamental-frequency magnitudes, synchronous to REF_CLK_I,
// in steps of 0.01 x motor_nominal_current, qualified by SAMPLE_VALID_I.
`timescale 1ns/1ps
`default_nettype none
`include "motor_start_params.svh"

module motor_start_supervision #(
  parameter int MS_TICK_CYCLES = `MS_TICK_CYCLES_DEF
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        SAMPLE_VALID_I,
  input  wire logic [15:0] PHASE_A_CURRENT_I,
  input  wire logic [15:0] PHASE_B_CURRENT_I,
  input  wire logic [15:0] PHASE_C_CURRENT_I,
  input  wire logic        SETTINGS_LOAD_I,
  input  wire logic [15:0] START_DETECT_THRESHOLD_I,
  input  wire logic [15:0] RATED_START_CURRENT_I,
  input  wire logic [15:0] FIXED_DELAY_TIME_I,
  input  wire logic [15:0] INV_TIME_COEFF_I,
  input  wire logic        DELAY_TYPE_I,
  input  wire logic        BLOCK_I,
  output logic             MOTOR_STOPPED_O,
  output logic             MOTOR_STARTING_O,
  output logic             MOTOR_RUNNING_O,
  output logic             START_O,
  output logic             TRIP_O
);

  // ========================================================================
  // Helpers
  // ========================================================================
  // Limits are compared against the phase sum, so the average needs no divider.
  function automatic logic [17:0] times3(input logic [15:0] x);
    return {2'b00, x} + {1'b0, x, 1'b0};
  endfunction

  function automatic logic [15:0] clamp(input logic [15:0] x, input logic [15:0] lo,
                                        input logic [15:0] hi);
    return (x < lo) ? lo : ((x > hi) ? hi : x);
  endfunction

  // ========================================================================
  // Reset release
  // ========================================================================
  logic rst_meta;
  logic rst_n;

  // Two stages so that the release never lands mid-cycle on the logic below.
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ========================================================================
  // Time base: millisecond enable and 0.1 s enable
  // ========================================================================
  logic [17:0] ms_cnt;
  logic        ms_tick;
  logic [6:0]  step_cnt;
  logic        step_tick;
  logic [17:0] next_ms_cnt;
  logic        next_ms_tick;
  logic [6:0]  next_step_cnt;
  logic        next_step_tick;

  always_comb begin
    next_ms_tick   = 1'b0;
    next_step_tick = 1'b0;
    next_step_cnt  = step_cnt;
    if (ms_cnt == 18'(MS_TICK_CYCLES - 1)) begin
      next_ms_cnt  = 18'h00000;
      next_ms_tick = 1'b1;
      if (step_cnt == `MS_OPER_STEP_MS - 7'h01) begin
        next_step_cnt  = 7'h00;
        next_step_tick = 1'b1;
      end else begin
        next_step_cnt = step_cnt + 7'h01;
      end
    end else begin
      next_ms_cnt = ms_cnt + 18'h00001;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt    <= 18'h00000;
      ms_tick   <= 1'b0;
      step_cnt  <= 7'h00;
      step_tick <= 1'b0;
    end else begin
      ms_cnt    <= next_ms_cnt;
      ms_tick   <= next_ms_tick;
      step_cnt  <= next_step_cnt;
      step_tick <= next_step_tick;
    end
  end

  // ========================================================================
  // Settings, clamped to their legal ranges when loaded
  // ========================================================================
  logic [15:0] thr_set;
  logic [15:0] rated_set;
  logic [15:0] dt_set;
  logic [15:0] k_set;
  logic [15:0] next_thr_set;
  logic [15:0] next_rated_set;
  logic [15:0] next_dt_set;
  logic [15:0] next_k_set;

  always_comb begin
    next_thr_set   = thr_set;
    next_rated_set = rated_set;
    next_dt_set    = dt_set;
    next_k_set     = k_set;
    if (SETTINGS_LOAD_I) begin
      next_thr_set   = clamp(START_DETECT_THRESHOLD_I, `MS_THR_MIN, `MS_THR_MAX);
      next_rated_set = clamp(RATED_START_CURRENT_I, `MS_RATED_MIN, `MS_RATED_MAX);
      next_dt_set    = clamp(FIXED_DELAY_TIME_I, `MS_DT_MIN, `MS_DT_MAX);
      next_k_set     = clamp(INV_TIME_COEFF_I, `MS_K_MIN, `MS_K_MAX);
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      thr_set   <= `MS_THR_DEF;
      rated_set <= `MS_RATED_DEF;
      dt_set    <= `MS_DT_DEF;
      k_set     <= `MS_K_DEF;
    end else begin
      thr_set   <= next_thr_set;
      rated_set <= next_rated_set;
      dt_set    <= next_dt_set;
      k_set     <= next_k_set;
    end
  end

  // ========================================================================
  // Motor state tracking
  // ========================================================================
  motor_start_pkg::motor_state_t state;
  motor_start_pkg::motor_state_t next_state;
  logic [17:0] sum;
  logic        sample_new;
  logic [9:0]  stop_ms;
  logic [7:0]  rise_ms;
  logic [17:0] next_sum;
  logic [9:0]  next_stop_ms;
  logic [7:0]  next_rise_ms;
  logic        below_stop;
  logic        below_run_low;
  logic        below_run_high;
  logic        above_thr;
  logic        stop_ok;

  assign below_stop     = sum < times3(`MS_STOPPED_LIM);
  assign below_run_low  = sum < times3(`MS_RUN_LOW_LIM);
  assign below_run_high = sum < times3(`MS_RUN_HIGH_LIM);
  assign above_thr      = sum > times3(thr_set);
  assign stop_ok        = stop_ms >= `MS_STOP_MIN_MS;

  always_comb begin
    next_state   = state;
    next_stop_ms = stop_ms;
    next_rise_ms = rise_ms;
    next_sum     = sum;
    if (SAMPLE_VALID_I) begin
      next_sum = {2'b00, PHASE_A_CURRENT_I} + {2'b00, PHASE_B_CURRENT_I}
               + {2'b00, PHASE_C_CURRENT_I};
    end
    case (state)
      motor_start_pkg::ST_STOPPED: begin
        next_rise_ms = 8'h00;
        if (!below_stop) begin
          next_state = motor_start_pkg::ST_RISE;
        end else if (ms_tick && !stop_ok) begin
          next_stop_ms = stop_ms + 10'h001;
        end
      end
      motor_start_pkg::ST_RISE: begin
        if (below_stop) begin
          // A dip back to stop restarts the continuous stop time.
          next_state   = motor_start_pkg::ST_STOPPED;
          next_stop_ms = 10'h000;
        end else if (above_thr && stop_ok && rise_ms < `MS_RISE_MAX_MS) begin
          next_state   = motor_start_pkg::ST_STARTING;
          next_stop_ms = 10'h000;
        end else if (rise_ms >= `MS_RISE_MAX_MS && !below_run_low) begin
          next_state   = motor_start_pkg::ST_RUNNING;
          next_stop_ms = 10'h000;
        end else if (ms_tick && rise_ms < `MS_RISE_MAX_MS) begin
          next_rise_ms = rise_ms + 8'h01;
        end
      end
      motor_start_pkg::ST_STARTING: begin
        if (below_stop) begin
          next_state = motor_start_pkg::ST_STOPPED;
        end else if (below_run_high) begin
          next_state = motor_start_pkg::ST_RUNNING;
        end
      end
      motor_start_pkg::ST_RUNNING: begin
        if (below_stop) begin
          next_state = motor_start_pkg::ST_STOPPED;
        end
      end
      default: begin
        next_state = motor_start_pkg::ST_STOPPED;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state      <= motor_start_pkg::ST_STOPPED;
      sum        <= 18'h00000;
      sample_new <= 1'b0;
      stop_ms    <= 10'h000;
      rise_ms    <= 8'h00;
    end else begin
      state      <= next_state;
      sum        <= next_sum;
      sample_new <= SAMPLE_VALID_I;
      stop_ms    <= next_stop_ms;
      rise_ms    <= next_rise_ms;
    end
  end

  // ========================================================================
  // Operate delay, start and trip
  // ========================================================================
  div_req_if div ();

  delay_divider u_delay_divider (
    .clk   (REF_CLK_I),
    .rst_n (rst_n),
    .div   (div)
  );

  logic        starting;
  logic        fixed_sel;
  logic [17:0] rated3;
  logic [19:0] oper_cnt;
  logic [19:0] inv_delay;
  logic        inv_ready;
  logic        div_go;
  logic [19:0] next_oper_cnt;
  logic [19:0] next_inv_delay;
  logic        next_inv_ready;
  logic        next_div_go;
  logic        next_start;
  logic        next_trip;
  logic [19:0] delay;

  assign starting  = state == motor_start_pkg::ST_STARTING;
  assign fixed_sel = DELAY_TYPE_I == motor_start_pkg::FIXED_DELAY_TYPE;
  assign rated3    = times3(rated_set);
  // The sum stands for three times the measured current, so the ratio needs rated x 3.
  assign div.numer = 40'(k_set) * 40'(rated3) * 40'(rated3);
  assign div.denom = 40'(sum) * 40'(sum);
  assign div.start = div_go;

  always_comb begin
    next_inv_delay = inv_delay;
    next_inv_ready = inv_ready;
    next_oper_cnt  = 20'h00000;
    // The dependent delay is refreshed on each new sample that finds the divider idle, so a sagging start current
    // stretches the allowed time while the start is still in progress.
    next_div_go = starting && sample_new && !div.busy && !div_go;
    if (!starting) begin
      next_inv_ready = 1'b0;
    end else if (div.done) begin
      next_inv_ready = 1'b1;
      next_inv_delay = (|div.quot[39:20]) ? 20'hFFFFF : div.quot[19:0];
    end
    if (starting && !BLOCK_I) begin
      next_oper_cnt = oper_cnt;
      if (step_tick && oper_cnt != 20'hFFFFF) begin
        next_oper_cnt = oper_cnt + 20'h00001;
      end
    end
    delay      = fixed_sel ? {4'h0, dt_set} : inv_delay;
    next_start = starting && !BLOCK_I;
    next_trip  = next_start && oper_cnt >= delay && (fixed_sel || inv_ready);
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      oper_cnt         <= 20'h00000;
      inv_delay        <= 20'h00000;
      inv_ready        <= 1'b0;
      div_go           <= 1'b0;
      START_O          <= 1'b0;
      TRIP_O           <= 1'b0;
      MOTOR_STOPPED_O  <= 1'b1;
      MOTOR_STARTING_O <= 1'b0;
      MOTOR_RUNNING_O  <= 1'b0;
    end else begin
      oper_cnt         <= next_oper_cnt;
      inv_delay        <= next_inv_delay;
      inv_ready        <= next_inv_ready;
      div_go           <= next_div_go;
      START_O          <= next_start;
      TRIP_O           <= next_trip;
      MOTOR_STOPPED_O  <= state == motor_start_pkg::ST_STOPPED
                       || state == motor_start_pkg::ST_RISE;
      MOTOR_STARTING_O <= starting;
      MOTOR_RUNNING_O  <= state == motor_start_pkg::ST_RUNNING;
    end
  end

endmodule

`default_nettype wire

// file: tb/motor_start_sva.sv
// Port-level checker of the motor start-up supervision stage.
// Assumes the bind in the bench top hands on the tick parameter.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Checker
// ==========================================================================
module motor_start_sva #(
  parameter int MS_TICK_CYCLES = 10
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        SAMPLE_VALID_I,
  input  wire logic [15:0] PHASE_A_CURRENT_I,
  input  wire logic [15:0] PHASE_B_CURRENT_I,
  input  wire logic [15:0] PHASE_C_CURRENT_I,
  input  wire logic        SETTINGS_LOAD_I,
  input  wire logic [15:0] START_DETECT_THRESHOLD_I,
  input  wire logic [15:0] RATED_START_CURRENT_I,
  input  wire logic [15:0] FIXED_DELAY_TIME_I,
  input  wire logic [15:0] INV_TIME_COEFF_I,
  input  wire logic        DELAY_TYPE_I,
  input  wire logic        BLOCK_I,
  input  wire logic        MOTOR_STOPPED_O,
  input  wire logic        MOTOR_STARTING_O,
  input  wire logic        MOTOR_RUNNING_O,
  input  wire logic        START_O,
  input  wire logic        TRIP_O
);
  localparam int STOP_MIN = 499 * MS_TICK_CYCLES;
  localparam int TRIP_MIN = 899 * MS_TICK_CYCLES;
  logic [17:0] phase_sum;
  logic [31:0] stop_run;
  logic [31:0] start_run;
  logic [31:0] next_stop_run;
  logic [31:0] next_start_run;

  // Exact sum; each limit is compared as three times its fraction of nominal.
  assign phase_sum = {2'h0, PHASE_A_CURRENT_I} + {2'h0, PHASE_B_CURRENT_I}
                   + {2'h0, PHASE_C_CURRENT_I};

  // Run lengths overestimate the design's own counts, so the bounds stay safe.
  always_comb begin
    next_stop_run = MOTOR_STOPPED_O ? stop_run + 32'h1 : 32'h0;
    next_start_run = START_O ? start_run + 32'h1 : 32'h0;
  end

  // Registers of the run lengths.
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      stop_run <= 32'h0;
      start_run <= 32'h0;
    end else begin
      stop_run <= next_stop_run;
      start_run <= next_start_run;
    end
  end

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  a_status_onehot: assert property (
    $onehot({MOTOR_STOPPED_O, MOTOR_STARTING_O, MOTOR_RUNNING_O})) else $error("status not one-hot");
  a_start_in_starting: assert property (START_O |-> MOTOR_STARTING_O)
    else $error("start outside starting");
  a_start_follows: assert property (
    $rose(MOTOR_STARTING_O) && !BLOCK_I && !$past(BLOCK_I) |-> ##[0:1] START_O)
    else $error("start missing on entry");
  a_block_quiet: assert property (BLOCK_I [*3] |-> !START_O && !TRIP_O)
    else $error("block did not suppress");
  a_trip_with_start: assert property (TRIP_O |-> START_O)
    else $error("trip without start");
  a_low_stops: assert property (
    SAMPLE_VALID_I && phase_sum < 18'h1E |-> ##[2:5] MOTOR_STOPPED_O)
    else $error("low current not stopped");
  a_start_entry: assert property (
    $rose(MOTOR_STARTING_O) |-> $fell(MOTOR_STOPPED_O) && stop_run >= STOP_MIN)
    else $error("starting without long stop");
  a_run_release: assert property (
    MOTOR_STARTING_O && SAMPLE_VALID_I && phase_sum >= 18'h1E && phase_sum < 18'h168
    |-> ##[2:5] MOTOR_RUNNING_O) else $error("no release below limit");
  a_run_exit: assert property ($fell(MOTOR_RUNNING_O) |-> MOTOR_STOPPED_O)
    else $error("running left to other than stopped");
  a_fixed_min: assert property (
    $rose(TRIP_O) && !DELAY_TYPE_I |-> start_run >= TRIP_MIN)
    else $error("fixed trip too early");
endmodule

`default_nettype wire

// file: tb/current_front_end.sv
// Phase current front end: one strobed three-phase sample per period.
// Assumes the bench sets the magnitudes; outputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Sample source
// ==========================================================================
module current_front_end #(
  parameter int PERIOD = 10
) (
  input  wire logic        clk_i,
  input  wire logic        en_i,
  input  wire logic [15:0] set_a_i,
  input  wire logic [15:0] set_b_i,
  input  wire logic [15:0] set_c_i,
  output logic             valid_o,
  output logic [15:0]      phase_a_o,
  output logic [15:0]      phase_b_o,
  output logic [15:0]      phase_c_o
);
  int cnt = 0;

  // Quiet outputs from time zero until the first falling edge.
  initial begin
    valid_o = 1'b0;
    phase_a_o = 16'h0000;
    phase_b_o = 16'h0000;
    phase_c_o = 16'h0000;
  end

  // Between strobes the phases carry the inverse, so unstrobed reads go wrong.
  always @(negedge clk_i) begin
    cnt = (cnt + 1) % PERIOD;
    valid_o <= en_i && (cnt == 0);
    phase_a_o <= (cnt == 0) ? set_a_i : ~set_a_i;
    phase_b_o <= (cnt == 0) ? set_b_i : ~set_b_i;
    phase_c_o <= (cnt == 0) ? set_c_i : ~set_c_i;
  end
endmodule

`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench of the motor start-up supervision stage.
// Assumes a shortened millisecond tick of ten clock cycles.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Bench top
// ==========================================================================
module tb_top;
  localparam int MS_TICK_CYCLES = 10;
  localparam int MS = MS_TICK_CYCLES;
  logic        clk;
  logic        rst_n;
  logic        front_en;
  logic        valid;
  logic        load;
  logic        dly_type;
  logic        block;
  logic [15:0] set_a, set_b, set_c, ph_a, ph_b, ph_c;
  logic [15:0] thr, rated, fdt, coeff;
  logic        stopped, starting, running, start, trip;
  int          errors = 0;
  int          check_count = 0;

  current_front_end #(.PERIOD(10)) feed (
    .clk_i(clk), .en_i(front_en), .set_a_i(set_a), .set_b_i(set_b), .set_c_i(set_c),
    .valid_o(valid), .phase_a_o(ph_a), .phase_b_o(ph_b), .phase_c_o(ph_c));

  motor_start_supervision #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) dut (
    .REF_CLK_I(clk), .RESETN_I(rst_n), .SAMPLE_VALID_I(valid),
    .PHASE_A_CURRENT_I(ph_a), .PHASE_B_CURRENT_I(ph_b), .PHASE_C_CURRENT_I(ph_c),
    .SETTINGS_LOAD_I(load), .START_DETECT_THRESHOLD_I(thr), .RATED_START_CURRENT_I(rated),
    .FIXED_DELAY_TIME_I(fdt), .INV_TIME_COEFF_I(coeff), .DELAY_TYPE_I(dly_type),
    .BLOCK_I(block), .MOTOR_STOPPED_O(stopped), .MOTOR_STARTING_O(starting),
    .MOTOR_RUNNING_O(running), .START_O(start), .TRIP_O(trip));

  // Clock of 5 ns.
  always #2.5 clk = ~clk;

  task automatic check(input string what, input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic logic stat(input int sel);
    case (sel)
      0: stat = stopped;
      1: stat = starting;
      2: stat = running;
      default: stat = trip;
    endcase
  endfunction

  // Bounded wait; a miss shows up in the comparison that follows.
  task automatic wait_for(input int sel, input int lim);
    int n;
    n = 0;
    while (stat(sel) !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  // Non-blocking so the front end reads the new magnitudes a step later, without a race.
  task automatic set_cur(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(negedge clk);
    set_a <= a;
    set_b <= b;
    set_c <= c;
  endtask

  task automatic load_set(input logic [15:0] t, r, f, k);
    @(negedge clk);
    thr = t;
    rated = r;
    fdt = f;
    coeff = k;
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 35000 cycles.
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    front_en = 1'b0;
    set_a = 16'h0000;
    set_b = 16'h0000;
    set_c = 16'h0000;
    {load, dly_type, block} = 3'h0;
    {thr, rated, fdt, coeff} = {16'h0258, 16'h0258, 16'h000A, 16'h000A};
    cyc(20);
    rst_n = 1'b1;
    cyc(3);
    check("reset stopped", stopped, 1'b1);
    check("reset starting", starting, 1'b0);
    check("reset start", start, 1'b0);
    check("reset trip", trip, 1'b0);
    front_en = 1'b1;
    cyc(550 * MS);
    // Direct start at 7.00 x nominal with default threshold and 1.0 s fixed delay.
    set_cur(16'h02BC, 16'h02BC, 16'h02BC);
    wait_for(1, 250 * MS);
    check("starting", starting, 1'b1);
    check("start", start, 1'b1);
    check("stopped left", stopped, 1'b0);
    cyc(890 * MS);
    check("trip early", trip, 1'b0);
    wait_for(3, 250 * MS);
    check("trip", trip, 1'b1);
    block = 1'b1;
    cyc(4);
    check("start blocked", start, 1'b0);
    check("trip blocked", trip, 1'b0);
    check("still starting", starting, 1'b1);
    block = 1'b0;
    cyc(4);
    check("start unblocked", start, 1'b1);
    check("timer cleared", trip, 1'b0);
    // Below 1.20 x nominal the stage lets go into running.
    set_cur(16'h0064, 16'h0064, 16'h0064);
    wait_for(2, 5 * MS);
    check("released", running, 1'b1);
    check("start released", start, 1'b0);
    // Average under 10 percent while one phase alone is above it.
    set_cur(16'h0019, 16'h0003, 16'h0001);
    wait_for(0, 5 * MS);
    check("stopped by average", stopped, 1'b1);
    check("running left", running, 1'b0);
    // Stop too short: a direct-start current gives running, never starting.
    cyc(100 * MS);
    set_cur(16'h02BC, 16'h02BC, 16'h02BC);
    cyc(250 * MS);
    check("short stop", starting, 1'b0);
    check("late running", running, 1'b1);
    // Soft start at half nominal never reaches the threshold.
    set_cur(16'h0000, 16'h0000, 16'h0000);
    cyc(550 * MS);
    set_cur(16'h0032, 16'h0032, 16'h0032);
    cyc(150 * MS);
    check("soft rise window", stopped, 1'b1);
    wait_for(2, 100 * MS);
    check("soft running", running, 1'b1);
    check("soft no start", starting, 1'b0);
    // Crossing the threshold long after leaving stop must not give starting.
    set_cur(16'h02BC, 16'h02BC, 16'h02BC);
    cyc(20 * MS);
    check("late threshold", starting, 1'b0);
    // Dependent delay; threshold 20.00 clamps to 10.00, coefficient 0.5 s to 1.0 s.
    set_cur(16'h0000, 16'h0000, 16'h0000);
    load_set(16'h07D0, 16'h0258, 16'h0BB8, 16'h0005);
    dly_type = 1'b1;
    cyc(550 * MS);
    set_cur(16'h04B0, 16'h04B0, 16'h04B0);
    wait_for(1, 250 * MS);
    check("clamped start", starting, 1'b1);
    cyc(90 * MS);
    check("dependent early", trip, 1'b0);
    wait_for(3, 250 * MS);
    check("dependent trip", trip, 1'b1);
    print_verdict();
  end
endmodule

bind motor_start_supervision motor_start_sva #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) sva (
  .REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I), .SAMPLE_VALID_I(SAMPLE_VALID_I),
  .PHASE_A_CURRENT_I(PHASE_A_CURRENT_I), .PHASE_B_CURRENT_I(PHASE_B_CURRENT_I),
  .PHASE_C_CURRENT_I(PHASE_C_CURRENT_I), .SETTINGS_LOAD_I(SETTINGS_LOAD_I),
  .START_DETECT_THRESHOLD_I(START_DETECT_THRESHOLD_I),
  .RATED_START_CURRENT_I(RATED_START_CURRENT_I), .FIXED_DELAY_TIME_I(FIXED_DELAY_TIME_I),
  .INV_TIME_COEFF_I(INV_TIME_COEFF_I), .DELAY_TYPE_I(DELAY_TYPE_I), .BLOCK_I(BLOCK_I),
  .MOTOR_STOPPED_O(MOTOR_STOPPED_O), .MOTOR_STARTING_O(MOTOR_STARTING_O),
  .MOTOR_RUNNING_O(MOTOR_RUNNING_O), .START_O(START_O), .TRIP_O(TRIP_O));

`default_nettype wire
